/* shared/msam_pkg.sv */
package msam_pkg;
  // mode codes {background, mode_b, mode_a}
  typedef enum logic [2:0] {
    MSAM_SPEC_SINGLE = 3'h0,
    MSAM_SPEC_NARROW = 3'h1,
    MSAM_SPEC_PERIPH = 3'h2,
    MSAM_SPEC_WIDE = 3'h3,
    MSAM_NORM_SINGLE = 3'h4,
    MSAM_NORM_NARROW = 3'h5,
    MSAM_RESERVED = 3'h6,
    MSAM_NORM_WIDE = 3'h7
  } msam_mode_t;

  typedef enum logic [2:0] {
    MSAM_SEL_NONE,
    MSAM_SEL_DBG_ROM,
    MSAM_SEL_REGS,
    MSAM_SEL_RAM,
    MSAM_SEL_EEPROM,
    MSAM_SEL_PROG,
    MSAM_SEL_EXT
  } msam_sel_t;

  // apb byte addresses
  localparam logic [7:0] MSAM_ADDR_MODE = 8'h00;
  localparam logic [7:0] MSAM_ADDR_REG_POS = 8'h04;
  localparam logic [7:0] MSAM_ADDR_RAM_POS = 8'h08;
  localparam logic [7:0] MSAM_ADDR_EE_POS = 8'h0C;
  localparam logic [7:0] MSAM_ADDR_DEBUG = 8'h10;
  localparam logic [7:0] MSAM_ADDR_DECODE = 8'h14;
  localparam logic [7:0] MSAM_ADDR_PORTS = 8'h18;

  // reset values of position fields (upper address bits) and the mapping write delay
  localparam logic [4:0] MSAM_REG_POS_RST = 5'h00;
  localparam logic [4:0] MSAM_RAM_POS_RST = 5'h01;
  localparam logic [3:0] MSAM_EE_POS_RST = 4'h0;
  localparam logic [1:0] MSAM_MAP_DELAY = 2'h2;

  // region geometry, plus the all-ports direction mask
  localparam logic [15:0] MSAM_DBG_ROM_BASE = 16'hFF00;
  localparam logic [15:0] MSAM_DBG_CTRL_TOP = 16'hFF06;
  localparam logic [15:0] MSAM_REG_SIZE = 16'h0200;
  localparam logic [15:0] MSAM_RAM_SIZE = 16'h0400;
  localparam logic [15:0] MSAM_EE_OFFS = 16'h0D00;
  localparam logic [15:0] MSAM_EE_SIZE = 16'h0300;
  localparam logic [15:0] MSAM_PROG_HI_BASE = 16'h8000;
  localparam logic [21:0] MSAM_PORT_ALL = 22'h3F_FFFF;
endpackage : msam_pkg

/* design/msam_mode_map.sv */
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
// Behaviour
// - reset-edge pin levels latched into mode bits
// - three-bit code selects one of eight modes
// - pull-up background, pull-downs mode pins in reset
// - wide: A/B multiplex address and 16-bit data
// - narrow: A high address plus data, B low
// - normal single-chip: ports are general I/O
// - reset enables port E pull-ups only
// - special wide: port E drives bus control
// - special narrow: external words as two bytes
// - special single-chip: skip vector, debug active
// - peripheral mode: processor idle, reset-only exit
// - debug activates by command/instruction once enabled
// - active debug ROM owns FF00-FFFF, except for serial debug accesses
// - serial debug: RW regs/RAM, read EEPROM/program
// - position registers write-once in normal modes
// - mapping writes effect two cycles later; one made while map_dly is 1 waits for a later position write
// - decoder priority debug, regs, RAM, EEPROM, program, external
// - expanded modes: unclaimed addresses go external
// - protection relaxed in special modes
// - debug enabled out of reset only special single-chip
// - mode bits writable, never peripheral or reserved
// - register block at zero, on 2K boundaries
module msam_mode_map (
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic background_debug_pin,
  input wire logic mode_select_b_pin,
  input wire logic mode_select_a_pin,
  output logic strap_pull_up,
  output logic strap_pull_down,
  input wire logic dbg_enable_cmd,
  input wire logic dbg_activate_cmd,
  input wire logic background_entry_instruction,
  input wire logic dbg_exit,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_valid,
  input wire logic cpu_word,
  input wire logic serial_dbg_access,
  input wire logic serial_dbg_write,
  output logic [2:0] region_sel,
  output logic access_denied,
  output logic byte_split,
  output logic high_byte_first,
  output logic fetch_reset_vector,
  output logic cpu_halt,
  output logic wide_bus,
  output logic narrow_bus,
  output logic ext_bus,
  output logic port_e_bus_ctrl,
  output logic port_e_pullup_en,
  output logic port_ab_pullup_en,
  output logic port_e_low_input_only,
  output logic [21:0] port_dir_rst
);
  typedef struct packed {
    logic [2:0] mode;
    logic mode_written;
    logic [4:0] reg_pos;
    logic [4:0] ram_pos;
    logic [3:0] ee_pos;
    logic reg_wr;
    logic ram_wr;
    logic ee_wr;
    logic [4:0] reg_eff;
    logic [4:0] ram_eff;
    logic [3:0] ee_eff;
    logic [1:0] map_dly;
    logic dbg_enabled;
    logic dbg_active;
    logic e_pull;
    logic ab_pull;
    logic in_reset;
    logic [31:0] rdata;
    logic [2:0] sel;
    logic denied;
  } msam_state_t;

  msam_state_t st_r;
  msam_state_t st_nxt;

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] base,
                                    input logic [15:0] size);
    in_range = (a >= base) && ((a - base) < size);
  endfunction : in_range

  function automatic logic is_special(input logic [2:0] m);
    is_special = ~m[2];
  endfunction : is_special

  msam_pkg::msam_mode_t mode_e;
  logic special;
  logic expanded;
  logic wr_acc;
  logic rd_acc;
  logic [15:0] reg_base;
  logic [15:0] ram_base;
  logic [15:0] ee_base;
  logic [15:0] prog_base;

  assign mode_e = msam_pkg::msam_mode_t'(st_r.mode);
  assign special = is_special(st_r.mode);
  // peripheral counts as expanded: external master owns the bus
  assign expanded = (st_r.mode[0] | st_r.mode[1]);
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  assign reg_base = {st_r.reg_eff, 11'h000};
  assign ram_base = {st_r.ram_eff, 11'h000};
  assign ee_base = {st_r.ee_eff, 12'h000} + msam_pkg::MSAM_EE_OFFS;
  assign prog_base = expanded ? 16'h0000 : msam_pkg::MSAM_PROG_HI_BASE;

  always_comb begin
    logic [2:0] wmode;
    logic allow_once;
    logic [15:0] a;
    wmode = pwdata[2:0];
    allow_once = 1'b0;
    a = cpu_addr;
    st_nxt = st_r;
    st_nxt.in_reset = 1'b0;
    // a mode change other than through reset stays inside the writable set
    if (wr_acc && paddr == msam_pkg::MSAM_ADDR_MODE) begin
      allow_once = special || !st_r.mode_written;
      if (allow_once && mode_e != msam_pkg::MSAM_SPEC_PERIPH
          && mode_e != msam_pkg::MSAM_RESERVED
          && wmode[1:0] != 2'b10) begin
        // special bit may only be set, never cleared by software
        st_nxt.mode = {st_r.mode[2] | (special & wmode[2]), wmode[1:0]};
        st_nxt.mode_written = 1'b1;
      end
    end
    if (wr_acc && paddr == msam_pkg::MSAM_ADDR_REG_POS && (special || !st_r.reg_wr)) begin
      st_nxt.reg_pos = pwdata[4:0];
      st_nxt.reg_wr = 1'b1;
      st_nxt.map_dly = msam_pkg::MSAM_MAP_DELAY;
    end
    if (wr_acc && paddr == msam_pkg::MSAM_ADDR_RAM_POS && (special || !st_r.ram_wr)) begin
      st_nxt.ram_pos = pwdata[4:0];
      st_nxt.ram_wr = 1'b1;
      st_nxt.map_dly = msam_pkg::MSAM_MAP_DELAY;
    end
    if (wr_acc && paddr == msam_pkg::MSAM_ADDR_EE_POS && (special || !st_r.ee_wr)) begin
      st_nxt.ee_pos = pwdata[3:0];
      st_nxt.ee_wr = 1'b1;
      st_nxt.map_dly = msam_pkg::MSAM_MAP_DELAY;
    end
    if (wr_acc && paddr == msam_pkg::MSAM_ADDR_PORTS) begin
      st_nxt.e_pull = pwdata[0];
      st_nxt.ab_pull = pwdata[1];
    end
    // decoder keeps old map for two cycles, new map lands on the third
    if (st_r.map_dly != 2'h0) begin
      st_nxt.map_dly = st_r.map_dly - 2'h1;
      if (st_r.map_dly == 2'h1) begin
        st_nxt.reg_eff = st_r.reg_pos;
        st_nxt.ram_eff = st_r.ram_pos;
        st_nxt.ee_eff = st_r.ee_pos;
      end
    end
    // debug unusable in peripheral mode due to bus conflicts
    if (mode_e != msam_pkg::MSAM_SPEC_PERIPH && mode_e != msam_pkg::MSAM_RESERVED) begin
      if (dbg_enable_cmd) begin
        st_nxt.dbg_enabled = 1'b1;
      end
      if (st_r.dbg_enabled && (dbg_activate_cmd || background_entry_instruction)) begin
        st_nxt.dbg_active = 1'b1;
      end else if (dbg_exit) begin
        st_nxt.dbg_active = 1'b0;
      end
    end
    // address decode in priority order
    st_nxt.sel = msam_pkg::MSAM_SEL_NONE;
    st_nxt.denied = 1'b0;
    if (cpu_valid) begin
      if (st_r.dbg_active && !serial_dbg_access && a >= msam_pkg::MSAM_DBG_ROM_BASE) begin
        st_nxt.sel = msam_pkg::MSAM_SEL_DBG_ROM;
      end else if (in_range(a, reg_base, msam_pkg::MSAM_REG_SIZE)) begin
        st_nxt.sel = msam_pkg::MSAM_SEL_REGS;
      end else if (in_range(a, ram_base, msam_pkg::MSAM_RAM_SIZE)) begin
        st_nxt.sel = msam_pkg::MSAM_SEL_RAM;
      end else if (in_range(a, ee_base, msam_pkg::MSAM_EE_SIZE)) begin
        st_nxt.sel = msam_pkg::MSAM_SEL_EEPROM;
      end else if (in_range(a, prog_base, msam_pkg::MSAM_PROG_HI_BASE) && !expanded) begin
        st_nxt.sel = msam_pkg::MSAM_SEL_PROG;
      end else if (expanded) begin
        st_nxt.sel = msam_pkg::MSAM_SEL_EXT;
      end
      if (serial_dbg_access && serial_dbg_write
          && (st_nxt.sel == msam_pkg::MSAM_SEL_EEPROM
              || st_nxt.sel == msam_pkg::MSAM_SEL_PROG)) begin
        st_nxt.denied = 1'b1;
      end
    end
    st_nxt.rdata = 32'h0000_0000;
    if (rd_acc) begin
      if (paddr == msam_pkg::MSAM_ADDR_MODE) begin
        st_nxt.rdata = {28'h000_0000, st_r.mode_written, st_r.mode};
      end else if (paddr == msam_pkg::MSAM_ADDR_REG_POS) begin
        st_nxt.rdata = {27'h000_0000, st_r.reg_pos};
      end else if (paddr == msam_pkg::MSAM_ADDR_RAM_POS) begin
        st_nxt.rdata = {27'h000_0000, st_r.ram_pos};
      end else if (paddr == msam_pkg::MSAM_ADDR_EE_POS) begin
        st_nxt.rdata = {28'h000_0000, st_r.ee_pos};
      end else if (paddr == msam_pkg::MSAM_ADDR_DEBUG) begin
        st_nxt.rdata = {30'h0000_0000, st_r.dbg_active, st_r.dbg_enabled};
      end else if (paddr == msam_pkg::MSAM_ADDR_DECODE) begin
        st_nxt.rdata = {28'h000_0000, st_r.denied, st_r.sel};
      end else if (paddr == msam_pkg::MSAM_ADDR_PORTS) begin
        st_nxt.rdata = {30'h0000_0000, st_r.ab_pull, st_r.e_pull};
      end
    end
  end

  // strap capture: pins sampled every reset cycle, last sample stands at release
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_r <= st_nxt;
      st_r.in_reset <= 1'b1;
      st_r.mode <= {background_debug_pin, mode_select_b_pin, mode_select_a_pin};
      st_r.mode_written <= 1'b0;
      st_r.reg_pos <= msam_pkg::MSAM_REG_POS_RST;
      st_r.ram_pos <= msam_pkg::MSAM_RAM_POS_RST;
      st_r.ee_pos <= msam_pkg::MSAM_EE_POS_RST;
      st_r.reg_eff <= msam_pkg::MSAM_REG_POS_RST;
      st_r.ram_eff <= msam_pkg::MSAM_RAM_POS_RST;
      st_r.ee_eff <= msam_pkg::MSAM_EE_POS_RST;
      st_r.reg_wr <= 1'b0;
      st_r.ram_wr <= 1'b0;
      st_r.ee_wr <= 1'b0;
      st_r.map_dly <= 2'h0;
      st_r.dbg_enabled <= ~background_debug_pin & ~mode_select_b_pin
                          & ~mode_select_a_pin;
      st_r.dbg_active <= ~background_debug_pin & ~mode_select_b_pin
                         & ~mode_select_a_pin;
      st_r.e_pull <= 1'b1;
      st_r.ab_pull <= 1'b0;
      st_r.rdata <= 32'h0000_0000;
      st_r.sel <= msam_pkg::MSAM_SEL_NONE;
      st_r.denied <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  logic rd_q;
  assign prdata = st_r.rdata;
  // one wait state so read data comes from a flop
  assign pready = psel & penable & (pwrite | rd_q);
  assign pslverr = 1'b0;
  always_ff @(posedge mclk) begin
    if (reset) begin
      rd_q <= 1'b0;
    end else begin
      rd_q <= rd_acc & ~rd_q;
    end
  end

  assign strap_pull_up = st_r.in_reset | reset;
  assign strap_pull_down = st_r.in_reset | reset;
  assign region_sel = st_r.sel;
  assign access_denied = st_r.denied;
  // only external word cycles split; internal paths stay 16 bits
  assign byte_split = mode_e == msam_pkg::MSAM_SPEC_NARROW && cpu_word
                      && st_r.sel == msam_pkg::MSAM_SEL_EXT;
  assign high_byte_first = byte_split;
  assign port_e_pullup_en = st_r.e_pull;
  assign port_ab_pullup_en = st_r.ab_pull;

  // port roles from the latched mode, one full row per code
  always_comb begin
    case (mode_e)
      msam_pkg::MSAM_SPEC_SINGLE: begin
        wide_bus = 1'b0;
        narrow_bus = 1'b0;
        ext_bus = 1'b0;
        port_e_bus_ctrl = 1'b0;
        fetch_reset_vector = 1'b0;
        cpu_halt = 1'b0;
        port_e_low_input_only = 1'b1;
        port_dir_rst = 22'h00_0000;
      end
      msam_pkg::MSAM_SPEC_NARROW: begin
        wide_bus = 1'b0;
        narrow_bus = 1'b1;
        ext_bus = 1'b1;
        port_e_bus_ctrl = 1'b0;
        fetch_reset_vector = 1'b1;
        cpu_halt = 1'b0;
        port_e_low_input_only = 1'b0;
        port_dir_rst = msam_pkg::MSAM_PORT_ALL;
      end
      msam_pkg::MSAM_SPEC_PERIPH: begin
        // external master owns ports A and B
        wide_bus = 1'b1;
        narrow_bus = 1'b0;
        ext_bus = 1'b1;
        port_e_bus_ctrl = 1'b0;
        fetch_reset_vector = 1'b0;
        cpu_halt = 1'b1;
        port_e_low_input_only = 1'b0;
        port_dir_rst = msam_pkg::MSAM_PORT_ALL;
      end
      msam_pkg::MSAM_SPEC_WIDE: begin
        wide_bus = 1'b1;
        narrow_bus = 1'b0;
        ext_bus = 1'b1;
        port_e_bus_ctrl = 1'b1;
        fetch_reset_vector = 1'b1;
        cpu_halt = 1'b0;
        port_e_low_input_only = 1'b0;
        port_dir_rst = msam_pkg::MSAM_PORT_ALL;
      end
      msam_pkg::MSAM_NORM_SINGLE: begin
        wide_bus = 1'b0;
        narrow_bus = 1'b0;
        ext_bus = 1'b0;
        port_e_bus_ctrl = 1'b0;
        fetch_reset_vector = 1'b1;
        cpu_halt = 1'b0;
        port_e_low_input_only = 1'b1;
        port_dir_rst = 22'h00_0000;
      end
      msam_pkg::MSAM_NORM_NARROW: begin
        wide_bus = 1'b0;
        narrow_bus = 1'b1;
        ext_bus = 1'b1;
        port_e_bus_ctrl = 1'b1;
        fetch_reset_vector = 1'b1;
        cpu_halt = 1'b0;
        port_e_low_input_only = 1'b0;
        port_dir_rst = msam_pkg::MSAM_PORT_ALL;
      end
      msam_pkg::MSAM_RESERVED: begin
        // reserved code gets the same port row as peripheral mode
        wide_bus = 1'b1;
        narrow_bus = 1'b0;
        ext_bus = 1'b1;
        port_e_bus_ctrl = 1'b0;
        fetch_reset_vector = 1'b0;
        cpu_halt = 1'b1;
        port_e_low_input_only = 1'b0;
        port_dir_rst = msam_pkg::MSAM_PORT_ALL;
      end
      msam_pkg::MSAM_NORM_WIDE: begin
        wide_bus = 1'b1;
        narrow_bus = 1'b0;
        ext_bus = 1'b1;
        port_e_bus_ctrl = 1'b1;
        fetch_reset_vector = 1'b1;
        cpu_halt = 1'b0;
        port_e_low_input_only = 1'b0;
        port_dir_rst = msam_pkg::MSAM_PORT_ALL;
      end
      default: begin
        wide_bus = 1'b0;
        narrow_bus = 1'b0;
        ext_bus = 1'b0;
        port_e_bus_ctrl = 1'b0;
        fetch_reset_vector = 1'b1;
        cpu_halt = 1'b0;
        port_e_low_input_only = 1'b1;
        port_dir_rst = 22'h00_0000;
      end
    endcase
  end
endmodule : msam_mode_map

/* testbench/msam_mode_map_props.sv */
`timescale 1ns/100ps
module msam_mode_map_props (
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic strap_pull_up,
  input wire logic strap_pull_down,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_valid,
  input wire logic [2:0] region_sel,
  input wire logic access_denied,
  input wire logic byte_split,
  input wire logic cpu_halt,
  input wire logic wide_bus,
  input wire logic narrow_bus,
  input wire logic ext_bus,
  input wire logic port_e_bus_ctrl,
  input wire logic port_e_pullup_en,
  input wire logic port_ab_pullup_en
);
  // default map holds until software first moves the register block
  logic remap_r;
  always_ff @(posedge mclk) begin
    remap_r <= !reset && (remap_r || (psel && penable && pready && pwrite
      && paddr == msam_pkg::MSAM_ADDR_REG_POS));
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  strap_pull_a: assert property ($fell(reset) |-> strap_pull_up && strap_pull_down)
    else $error("strap pulls dropped too early");
  pull_reset_a: assert property ($fell(reset) |-> port_e_pullup_en && !port_ab_pullup_en)
    else $error("port pull-ups wrong after reset");
  write_wait_a: assert property (psel && penable && pwrite |-> pready)
    else $error("write not answered at once");
  read_wait_a: assert property (psel && !penable && !pwrite ##1 psel && penable
    |-> !pready ##1 pready) else $error("read answer timing wrong");
  regs_first_a: assert property (cpu_valid && cpu_addr < 16'h0200 && !remap_r
    |=> region_sel == msam_pkg::MSAM_SEL_REGS)
    else $error("register block not chosen");
  ext_needs_bus_a: assert property (region_sel == msam_pkg::MSAM_SEL_EXT |-> ext_bus)
    else $error("external decode without bus");
  split_narrow_a: assert property (byte_split |-> narrow_bus
    && region_sel == msam_pkg::MSAM_SEL_EXT)
    else $error("byte split outside narrow external");
  halt_stable_a: assert property (!$past(reset) |-> $stable(cpu_halt))
    else $error("halt changed between resets");
  ctrl_ext_a: assert property (port_e_bus_ctrl |-> ext_bus)
    else $error("bus control without external bus");
  deny_rom_a: assert property (access_denied |-> region_sel inside
    {msam_pkg::MSAM_SEL_EEPROM, msam_pkg::MSAM_SEL_PROG})
    else $error("denied access to writable place");
  cover property (byte_split);
  cover property (access_denied);
  cover property (region_sel == msam_pkg::MSAM_SEL_DBG_ROM);
endmodule : msam_mode_map_props
bind msam_mode_map msam_mode_map_props chk_u (.*);

/* testbench/msam_strap_board.sv */
`timescale 1ns/100ps
module msam_strap_board (
  input wire logic mclk,
  input wire logic [2:0] con,
  input wire logic [2:0] lvl,
  input wire logic strap_pull_up,
  input wire logic strap_pull_down,
  output logic [2:0] pins
);
  logic flip_r = 1'b0;
  always_ff @(posedge mclk) begin
    flip_r <= !flip_r;
  end
  // open pins follow the device pulls, else wander so no stale level hides
  assign pins[2] = con[2] ? lvl[2] : (strap_pull_up ? 1'b1 : flip_r);
  assign pins[1] = con[1] ? lvl[1] : (strap_pull_down ? 1'b0 : flip_r);
  assign pins[0] = con[0] ? lvl[0] : (strap_pull_down ? 1'b0 : flip_r);
endmodule : msam_strap_board

/* testbench/msam_mode_map_tb.sv */
`timescale 1ns/100ps
module msam_mode_map_tb;
  localparam logic [7:0] wide_m = 8'hCC;
  localparam logic [7:0] narrow_m = 8'h22;
  localparam logic [7:0] halt_m = 8'h44;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, pu, pd, cpu_valid = 1'b0, cpu_word = 1'b0, sdbg = 1'b0, swr = 1'b0;
  logic [2:0] con = 3'h7, lvl = 3'h4, pins, region_sel;
  logic [3:0] pulses = 4'h0;
  logic [15:0] cpu_addr = 16'h0000;
  logic access_denied, byte_split, high_first, fetch_vec, cpu_halt, wide_bus, narrow_bus;
  logic ext_bus, e_ctrl, e_pull, ab_pull, e_low_in;
  logic [21:0] port_dir_rst;
  int miscompares = 0, n_checks = 0, cyc = 0;
  always #10 mclk = ~mclk;
  msam_strap_board board_u (.mclk(mclk), .con(con), .lvl(lvl), .strap_pull_up(pu),
    .strap_pull_down(pd), .pins(pins));
  msam_mode_map dut_u (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .background_debug_pin(pins[2]), .mode_select_b_pin(pins[1]),
    .mode_select_a_pin(pins[0]), .strap_pull_up(pu), .strap_pull_down(pd),
    .dbg_enable_cmd(pulses[3]), .dbg_activate_cmd(pulses[2]),
    .background_entry_instruction(pulses[1]), .dbg_exit(pulses[0]),
    .cpu_addr(cpu_addr), .cpu_valid(cpu_valid), .cpu_word(cpu_word),
    .serial_dbg_access(sdbg), .serial_dbg_write(swr), .region_sel(region_sel),
    .access_denied(access_denied), .byte_split(byte_split), .high_byte_first(high_first),
    .fetch_reset_vector(fetch_vec), .cpu_halt(cpu_halt), .wide_bus(wide_bus),
    .narrow_bus(narrow_bus), .ext_bus(ext_bus), .port_e_bus_ctrl(e_ctrl),
    .port_e_pullup_en(e_pull), .port_ab_pullup_en(ab_pull),
    .port_e_low_input_only(e_low_in), .port_dir_rst(port_dir_rst));
  task results();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end
  task chk32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk32
  task chk1(input logic got, input logic exp);
    chk32(32'(got), 32'(exp));
  endtask : chk1
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    {psel, penable} <= 2'h0;
  endtask : apb
  task rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk32(rd & m, e);
  endtask : rdchk
  task rst(input logic [2:0] c, input logic [2:0] l);
    @(posedge mclk);
    {reset, con, lvl} <= {1'b1, c, l};
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    #1;
  endtask : rst
  task dec(input logic [15:0] a, input logic w, input logic s, input logic wr, input logic [2:0] e);
    @(posedge mclk);
    {cpu_addr, cpu_valid, cpu_word, sdbg, swr} <= {a, 1'b1, w, s, wr};
    repeat (2) @(posedge mclk);
    chk32(32'(region_sel), 32'(e));
  endtask : dec
  task pulse(input logic [3:0] v);
    @(posedge mclk);
    pulses <= v;
    @(posedge mclk);
    pulses <= 4'h0;
  endtask : pulse
  task t_straps();
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      rst(3'h7, c);
      chk1(wide_bus, wide_m[i]);
      chk1(narrow_bus, narrow_m[i]);
      chk1(cpu_halt, halt_m[i]);
      chk1(e_pull, 1'b1);
      chk1(ab_pull, 1'b0);
      if (c[1:0] != 2'h2) chk1(ext_bus, c[0]);
      if (c[1:0] == 2'h0) chk32(32'(port_dir_rst), 32'h0000_0000);
      if (c == 3'h4) chk1(e_low_in, 1'b1);
      if (c == 3'h3) chk1(e_ctrl, 1'b1);
      if (c == 3'h1) chk1(e_ctrl, 1'b0);
      if (c == 3'h0 || c == 3'h4) chk1(fetch_vec, c[2]);
      if (c[1:0] != 2'h2) rdchk(msam_pkg::MSAM_ADDR_MODE, 32'h0000_0007, 32'(c));
      rdchk(msam_pkg::MSAM_ADDR_DEBUG, 32'h0000_0003, (c == 3'h0) ? 32'h0000_0003 : 32'h0000_0000);
    end
    $display("test straps done");
  endtask : t_straps
  task t_float();
    rst(3'h0, 3'h0);
    rdchk(msam_pkg::MSAM_ADDR_MODE, 32'h0000_0007, 32'h0000_0004);
    repeat (7) @(posedge mclk);
    rdchk(msam_pkg::MSAM_ADDR_MODE, 32'h0000_0007, 32'h0000_0004);
    $display("test open straps done");
  endtask : t_float
  task t_map();
    rst(3'h7, 3'h4);
    dec(16'h0100, 1'b0, 1'b0, 1'b0, msam_pkg::MSAM_SEL_REGS);
    dec(16'h0900, 1'b0, 1'b0, 1'b0, msam_pkg::MSAM_SEL_RAM);
    dec(16'h0E00, 1'b0, 1'b0, 1'b0, msam_pkg::MSAM_SEL_EEPROM);
    dec(16'h9000, 1'b0, 1'b0, 1'b0, msam_pkg::MSAM_SEL_PROG);
    dec(16'h4000, 1'b0, 1'b0, 1'b0, msam_pkg::MSAM_SEL_NONE);
    apb(1'b1, msam_pkg::MSAM_ADDR_REG_POS, 32'h0000_0001);
    apb(1'b1, msam_pkg::MSAM_ADDR_REG_POS, 32'h0000_0002);
    rdchk(msam_pkg::MSAM_ADDR_REG_POS, 32'h0000_001F, 32'h0000_0001);
    dec(16'h0900, 1'b0, 1'b0, 1'b0, msam_pkg::MSAM_SEL_REGS);
    dec(16'h0A00, 1'b0, 1'b1, 1'b1, msam_pkg::MSAM_SEL_RAM);
    chk1(access_denied, 1'b0);
    dec(16'h0E00, 1'b0, 1'b1, 1'b1, msam_pkg::MSAM_SEL_EEPROM);
    chk1(access_denied, 1'b1);
    dec(16'h0E00, 1'b0, 1'b1, 1'b0, msam_pkg::MSAM_SEL_EEPROM);
    chk1(access_denied, 1'b0);
    rst(3'h7, 3'h7);
    dec(16'h4000, 1'b0, 1'b0, 1'b0, msam_pkg::MSAM_SEL_EXT);
    dec(16'h9000, 1'b0, 1'b0, 1'b0, msam_pkg::MSAM_SEL_EXT);
    rst(3'h7, 3'h3);
    apb(1'b1, msam_pkg::MSAM_ADDR_REG_POS, 32'h0000_0001);
    apb(1'b1, msam_pkg::MSAM_ADDR_REG_POS, 32'h0000_0002);
    rdchk(msam_pkg::MSAM_ADDR_REG_POS, 32'h0000_001F, 32'h0000_0002);
    $display("test map done");
  endtask : t_map
  task t_mode();
    rst(3'h7, 3'h4);
    apb(1'b1, msam_pkg::MSAM_ADDR_MODE, 32'h0000_0005);
    rdchk(msam_pkg::MSAM_ADDR_MODE, 32'h0000_0007, 32'h0000_0005);
    chk1(narrow_bus, 1'b1);
    apb(1'b1, msam_pkg::MSAM_ADDR_MODE, 32'h0000_0007);
    rdchk(msam_pkg::MSAM_ADDR_MODE, 32'h0000_0007, 32'h0000_0005);
    rst(3'h7, 3'h0);
    apb(1'b1, msam_pkg::MSAM_ADDR_MODE, 32'h0000_0002);
    rdchk(msam_pkg::MSAM_ADDR_MODE, 32'h0000_0007, 32'h0000_0000);
    apb(1'b1, msam_pkg::MSAM_ADDR_MODE, 32'h0000_0001);
    apb(1'b1, msam_pkg::MSAM_ADDR_MODE, 32'h0000_0003);
    rdchk(msam_pkg::MSAM_ADDR_MODE, 32'h0000_0007, 32'h0000_0003);
    chk1(wide_bus, 1'b1);
    $display("test mode writes done");
  endtask : t_mode
  task t_debug();
    rst(3'h7, 3'h4);
    pulse(4'h4);
    rdchk(msam_pkg::MSAM_ADDR_DEBUG, 32'h0000_0003, 32'h0000_0000);
    pulse(4'h8);
    rdchk(msam_pkg::MSAM_ADDR_DEBUG, 32'h0000_0003, 32'h0000_0001);
    pulse(4'h2);
    rdchk(msam_pkg::MSAM_ADDR_DEBUG, 32'h0000_0003, 32'h0000_0003);
    dec(16'hFF80, 1'b0, 1'b0, 1'b0, msam_pkg::MSAM_SEL_DBG_ROM);
    dec(16'hFF80, 1'b0, 1'b1, 1'b0, msam_pkg::MSAM_SEL_PROG);
    pulse(4'h1);
    dec(16'hFF80, 1'b0, 1'b0, 1'b0, msam_pkg::MSAM_SEL_PROG);
    pulse(4'h4);
    rdchk(msam_pkg::MSAM_ADDR_DEBUG, 32'h0000_0003, 32'h0000_0003);
    $display("test debug done");
  endtask : t_debug
  task t_split();
    rst(3'h7, 3'h1);
    dec(16'h4000, 1'b1, 1'b0, 1'b0, msam_pkg::MSAM_SEL_EXT);
    chk1(byte_split, 1'b1);
    chk1(high_first, 1'b1);
    dec(16'h4000, 1'b0, 1'b0, 1'b0, msam_pkg::MSAM_SEL_EXT);
    chk1(byte_split, 1'b0);
    rst(3'h7, 3'h3);
    dec(16'h4000, 1'b1, 1'b0, 1'b0, msam_pkg::MSAM_SEL_EXT);
    chk1(byte_split, 1'b0);
    $display("test byte split done");
  endtask : t_split
  initial begin
    t_straps();
    t_float();
    t_map();
    t_mode();
    t_debug();
    t_split();
    results();
  end
endmodule : msam_mode_map_tb
